/* File: hdl/ecu_pkg.sv */
// ecu_pkg: offsets, fields, codes and reset values of the edge capture unit
// assumes an 8-bit register port and a 40 MHz sys_clk
package ecu_pkg;
  // sizes
  localparam int unsigned NUNITS = 2;
  localparam int unsigned CNT_W  = 16;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PS_W   = 4;
  // register offsets
  localparam logic [7:0] UNIT_STRIDE = 8'h04;
  localparam logic [7:0] OFF_CTL     = 8'h00;
  localparam logic [7:0] OFF_SRC     = 8'h01;
  localparam logic [7:0] OFF_LOW     = 8'h02;
  localparam logic [7:0] OFF_HIGH    = 8'h03;
  localparam logic [7:0] OFF_TSEL    = 8'h08;
  localparam logic [7:0] OFF_FLAG    = 8'h09;
  localparam logic [7:0] OFF_IEN     = 8'h0a;
  // control field positions
  localparam int unsigned CTL_EN_BIT = 7;
  localparam int unsigned MODE_W     = 4;
  localparam int unsigned TSEL_W     = 2;
  // capture modes
  localparam logic [3:0] MODE_BOTH   = 4'h3;
  localparam logic [3:0] MODE_FALL   = 4'h4;
  localparam logic [3:0] MODE_RISE   = 4'h5;
  localparam logic [3:0] MODE_RISE4  = 4'h6;
  localparam logic [3:0] MODE_RISE16 = 4'h7;
  localparam logic [3:0] PS4_LAST    = 4'h3;
  localparam logic [3:0] PS16_LAST   = 4'hf;
  // capture sources
  localparam logic [1:0] SRC_PIN  = 2'h0;
  localparam logic [1:0] SRC_CMP1 = 2'h1;
  localparam logic [1:0] SRC_CMP2 = 2'h2;
  localparam logic [1:0] SRC_PCE  = 2'h3;
  // reset values
  localparam logic [7:0] CTL_RST  = 8'h00;
  localparam logic [1:0] SRC_RST  = 2'h0;
  localparam logic [1:0] TSEL_RST = 2'h0;
  // instruction clock: sys_clk divided by four
  localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
endpackage

/* File: hdl/ecu_edge_sync.sv */
// ecu_edge_sync: two-flop synchroniser and edge detector for one input
// assumes the input is asynchronous to sys_clk
`timescale 1ns/100ps
`default_nettype none
module ecu_edge_sync
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic reset_n,
  // raw input
  input  wire logic din,
  // detected edges
  output logic      rise,
  output logic      fall
);
  logic meta_r;
  logic sync_r;
  logic last_r;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end
    else
    begin
      meta_r <= din;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  // one pulse per physical edge
  assign rise = sync_r & ~last_r;
  assign fall = ~sync_r & last_r;
endmodule
`default_nettype wire

/* File: hdl/ecu_capture_unit.sv */
// ecu_capture_unit: edge qualification, prescaler and capture value of one unit
// assumes edges are one-cycle pulses on sys_clk
`timescale 1ns/100ps
`default_nettype none
module ecu_capture_unit
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // configuration
  input  wire logic        en,
  input  wire logic [3:0]  mode,
  // qualified input edges
  input  wire logic        rise,
  input  wire logic        fall,
  // assigned timer
  input  wire logic [15:0] timer_count,
  // software writes of the value bytes
  input  wire logic        wr_low,
  input  wire logic        wr_high,
  input  wire logic [7:0]  wdata,
  // results
  output logic             cap_pulse,
  output logic [15:0]      cap_value,
  output logic [3:0]       presc_cnt
);
  logic is_cap;
  logic ps_hit;

  assign is_cap = (mode == ecu_pkg::MODE_BOTH) || (mode == ecu_pkg::MODE_FALL) ||
                  (mode == ecu_pkg::MODE_RISE) || (mode == ecu_pkg::MODE_RISE4) ||
                  (mode == ecu_pkg::MODE_RISE16);

  // compare with >=: a switch of ratio may fire early
  always_comb
  begin
    ps_hit = 1'b0;
    if (mode == ecu_pkg::MODE_RISE4)
      ps_hit = presc_cnt >= ecu_pkg::PS4_LAST;
    else if (mode == ecu_pkg::MODE_RISE16)
      ps_hit = presc_cnt >= ecu_pkg::PS16_LAST;
  end

  always_comb
  begin
    case (mode)
      ecu_pkg::MODE_BOTH:   cap_pulse = en & (rise | fall);
      ecu_pkg::MODE_FALL:   cap_pulse = en & fall;
      ecu_pkg::MODE_RISE:   cap_pulse = en & rise;
      ecu_pkg::MODE_RISE4,
      ecu_pkg::MODE_RISE16: cap_pulse = en & rise & ps_hit;
      default:              cap_pulse = 1'b0;
    endcase
  end

  // held clear when off or not capturing
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      presc_cnt <= 4'h0;
    else if (!en || !is_cap)
      presc_cnt <= 4'h0;
    else if (rise && (mode == ecu_pkg::MODE_RISE4 || mode == ecu_pkg::MODE_RISE16))
      presc_cnt <= ps_hit ? 4'h0 : presc_cnt + 4'h1;
  end

  // overwrite without protection, capture beats software
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      cap_value <= 16'h0000;
    else if (cap_pulse)
      cap_value <= timer_count;
    else if (wr_low)
      cap_value[7:0] <= wdata;
    else if (wr_high)
      cap_value[15:8] <= wdata;
  end
endmodule
`default_nettype wire

/* File: hdl/ecu_top.sv */
// ecu_top: two capture units, timer assignment, flags and register port
// assumes wide timer counts come from logic on sys_clk, event sources do not
`timescale 1ns/100ps
`default_nettype none
module ecu_top
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // wide timers
  input  wire logic [15:0] wide_timer_count_a,
  input  wire logic [15:0] wide_timer_count_b,
  input  wire logic [15:0] wide_timer_count_c,
  // power state
  input  wire logic        sleep_req,
  output logic             instr_tick,
  // event sources
  input  wire logic [1:0]  capture_unit_pin,
  input  wire logic [1:0]  pin_direction_bit,
  input  wire logic [1:0]  port_out_latch,
  input  wire logic        comparator_one_out,
  input  wire logic        comparator_two_out,
  input  wire logic        pin_change_event,
  // unit status
  output logic      [1:0]  unit_event_flag,
  output logic      [1:0]  unit_event_enable,
  output logic      [1:0]  capture_pulse,
  output logic      [1:0]  timer_assign_field_0,
  output logic      [1:0]  timer_assign_field_1
);
  ////////////////////////////////////////////////////////////////////////////
  // decode helpers
  function automatic logic unit_hit(input logic [7:0] a, input int unsigned u,
                                    input logic [7:0] off);
    logic [7:0] base;
    base = 8'(u) * ecu_pkg::UNIT_STRIDE;
    return a == (base + off);
  endfunction

  function automatic logic [15:0] pick_timer(input logic [1:0] sel, input logic [15:0] ta,
                                             input logic [15:0] tb, input logic [15:0] tc);
    logic [15:0] t;
    t = ta;
    if (sel == 2'h1)
      t = tb;
    else if (sel == 2'h2)
      t = tc;
    return t;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // instruction clock enable
  logic [1:0] div_r;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      div_r <= 2'h0;
    else
      div_r <= div_r + 2'h1;
  end

  // timers run from this tick, never from raw sys_clk
  assign instr_tick = (div_r == ecu_pkg::INSTR_DIV_LAST) & ~sleep_req;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0]  ctl_r   [2];
  logic [1:0]  src_r   [2];
  logic [1:0]  tsel_r  [2];
  logic [1:0]  flag_r;
  logic [1:0]  ien_r;
  logic [15:0] cap_val [2];
  logic [3:0]  presc   [2];
  logic [15:0] tmr_sel [2];
  logic [1:0]  src_raw;
  logic [1:0]  rise;
  logic [1:0]  fall;
  logic [7:0]  rd_nxt;

  // units independent, may pick the same timer
  genvar gu;
  generate
    for (gu = 0; gu < 2; gu++)
    begin : g_unit
      always_ff @(posedge sys_clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          ctl_r[gu] <= ecu_pkg::CTL_RST;
          src_r[gu] <= ecu_pkg::SRC_RST;
        end
        else if (reg_wr)
        begin
          if (unit_hit(reg_addr, gu, ecu_pkg::OFF_CTL))
            ctl_r[gu] <= reg_wdata;
          else if (unit_hit(reg_addr, gu, ecu_pkg::OFF_SRC))
            src_r[gu] <= reg_wdata[1:0];
        end
      end

      // output pin reflects the port latch
      always_comb
      begin
        case (src_r[gu])
          ecu_pkg::SRC_CMP1: src_raw[gu] = comparator_one_out;
          ecu_pkg::SRC_CMP2: src_raw[gu] = comparator_two_out;
          ecu_pkg::SRC_PCE:  src_raw[gu] = pin_change_event;
          default:           src_raw[gu] = pin_direction_bit[gu] ? capture_unit_pin[gu]
                                                                 : port_out_latch[gu];
        endcase
      end

      ecu_edge_sync u_sync
      (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .din     (src_raw[gu]),
        .rise    (rise[gu]),
        .fall    (fall[gu])
      );

      // timer count assumed synchronous to sys_clk
      assign tmr_sel[gu] = pick_timer(tsel_r[gu], wide_timer_count_a,
                                      wide_timer_count_b, wide_timer_count_c);

      ecu_capture_unit u_cap
      (
        .sys_clk     (sys_clk),
        .reset_n     (reset_n),
        .en          (ctl_r[gu][ecu_pkg::CTL_EN_BIT]),
        .mode        (ctl_r[gu][ecu_pkg::MODE_W-1:0]),
        .rise        (rise[gu]),
        .fall        (fall[gu]),
        .timer_count (tmr_sel[gu]),
        .wr_low      (reg_wr && unit_hit(reg_addr, gu, ecu_pkg::OFF_LOW)),
        .wr_high     (reg_wr && unit_hit(reg_addr, gu, ecu_pkg::OFF_HIGH)),
        .wdata       (reg_wdata),
        .cap_pulse   (capture_pulse[gu]),
        .cap_value   (cap_val[gu]),
        .presc_cnt   (presc[gu])
      );

      // hardware sets, software clears, set wins
      // a mode change may produce a false capture
      always_ff @(posedge sys_clk or negedge reset_n)
      begin
        if (!reset_n)
          flag_r[gu] <= 1'b0;
        else if (capture_pulse[gu])
          flag_r[gu] <= 1'b1;
        else if (reg_wr && reg_addr == ecu_pkg::OFF_FLAG && reg_wdata[gu])
          flag_r[gu] <= 1'b0;
      end
    end
  endgenerate

  // both fields reset to the first timer
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tsel_r[0] <= ecu_pkg::TSEL_RST;
      tsel_r[1] <= ecu_pkg::TSEL_RST;
    end
    else if (reg_wr && reg_addr == ecu_pkg::OFF_TSEL)
    begin
      tsel_r[0] <= reg_wdata[1:0];
      tsel_r[1] <= reg_wdata[3:2];
    end
  end

  // interrupt enable lives here, gating is done elsewhere
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      ien_r <= 2'h0;
    else if (reg_wr && reg_addr == ecu_pkg::OFF_IEN)
      ien_r <= reg_wdata[1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // read side
  // value readable as low and high byte
  always_comb
  begin
    rd_nxt = 8'h00;
    if (unit_hit(reg_addr, 0, ecu_pkg::OFF_CTL))
      rd_nxt = ctl_r[0];
    else if (unit_hit(reg_addr, 0, ecu_pkg::OFF_SRC))
      rd_nxt = {6'h00, src_r[0]};
    else if (unit_hit(reg_addr, 0, ecu_pkg::OFF_LOW))
      rd_nxt = cap_val[0][7:0];
    else if (unit_hit(reg_addr, 0, ecu_pkg::OFF_HIGH))
      rd_nxt = cap_val[0][15:8];
    else if (unit_hit(reg_addr, 1, ecu_pkg::OFF_CTL))
      rd_nxt = ctl_r[1];
    else if (unit_hit(reg_addr, 1, ecu_pkg::OFF_SRC))
      rd_nxt = {6'h00, src_r[1]};
    else if (unit_hit(reg_addr, 1, ecu_pkg::OFF_LOW))
      rd_nxt = cap_val[1][7:0];
    else if (unit_hit(reg_addr, 1, ecu_pkg::OFF_HIGH))
      rd_nxt = cap_val[1][15:8];
    else if (reg_addr == ecu_pkg::OFF_TSEL)
      rd_nxt = {4'h0, tsel_r[1], tsel_r[0]};
    else if (reg_addr == ecu_pkg::OFF_FLAG)
      rd_nxt = {6'h00, flag_r};
    else if (reg_addr == ecu_pkg::OFF_IEN)
      rd_nxt = {6'h00, ien_r};
  end

  // data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rd_nxt;
    else
      reg_rdata <= 8'h00;
  end

  assign unit_event_flag      = flag_r;
  assign unit_event_enable    = ien_r;
  assign timer_assign_field_0 = tsel_r[0];
  assign timer_assign_field_1 = tsel_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  AST_CAPTURE_LOADS: assert property (
    capture_pulse[0] |=> cap_val[0] == $past(tmr_sel[0]))
    else $error("capture value not the timer count");

  AST_FLAG_SETS: assert property (
    capture_pulse[1] |=> flag_r[1])
    else $error("capture did not set flag");

  AST_FLAG_HOLDS: assert property (
    flag_r[0] && !(reg_wr && reg_addr == ecu_pkg::OFF_FLAG && reg_wdata[0]) |=> flag_r[0])
    else $error("flag cleared without software");

  AST_PRESC_OFF: assert property (
    !ctl_r[0][ecu_pkg::CTL_EN_BIT] |=> presc[0] == 4'h0)
    else $error("prescaler not cleared while off");

  AST_FALLING: assert property (
    ctl_r[0] == {1'b1, 3'h0, ecu_pkg::MODE_FALL} && fall[0] |-> capture_pulse[0])
    else $error("falling edge not captured");

  AST_PRESC4: assert property (
    ctl_r[0] == {1'b1, 3'h0, ecu_pkg::MODE_RISE4} && rise[0] |-> capture_pulse[0] == (presc[0] >= ecu_pkg::PS4_LAST))
    else $error("fourth rising edge not captured");

  AST_SLEEP_TICK: assert property (
    sleep_req |-> !instr_tick)
    else $error("instruction tick during sleep");

  AST_READ_LOW: assert property (
    reg_rd && reg_addr == ecu_pkg::OFF_LOW && !capture_pulse[0] && !reg_wr
    |=> reg_rdata == cap_val[0][7:0])
    else $error("low byte read wrong");

  AST_READ_HIGH: assert property (
    reg_rd && reg_addr == ecu_pkg::OFF_HIGH && !capture_pulse[0] && !reg_wr |=> reg_rdata == cap_val[0][15:8])
    else $error("high byte read wrong");

  AST_RDATA_ZERO: assert property (
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside the answer cycle");

  AST_CAPTURE_LOADS1: assert property (
    capture_pulse[1] |=> cap_val[1] == $past(tmr_sel[1]))
    else $error("unit one value not the timer count");

  AST_OVERWRITE: assert property (
    flag_r[0] && capture_pulse[0] |=> cap_val[0] == $past(tmr_sel[0]))
    else $error("pending value not overwritten");

  AST_FLAG_SETS0: assert property (
    capture_pulse[0] |=> flag_r[0])
    else $error("unit zero capture did not set flag");

  AST_FLAG_CLEARS: assert property (
    flag_r[0] && !capture_pulse[0] && reg_wr && reg_addr == ecu_pkg::OFF_FLAG && reg_wdata[0]
    |=> !flag_r[0])
    else $error("software clear of flag lost");

  AST_BOTH_EDGES: assert property (
    ctl_r[0] == {1'b1, 3'h0, ecu_pkg::MODE_BOTH} && (rise[0] || fall[0]) |-> capture_pulse[0])
    else $error("edge not captured in either-edge mode");

  AST_PRESC_NOCAP: assert property (
    ctl_r[0][3:0] < ecu_pkg::MODE_BOTH |=> presc[0] == 4'h0)
    else $error("prescaler not cleared outside capture modes");

  AST_SRC_CMP1: assert property (
    src_r[0] == ecu_pkg::SRC_CMP1 |-> src_raw[0] == comparator_one_out)
    else $error("comparator one not selected");

  AST_SRC_PCE: assert property (
    src_r[1] == ecu_pkg::SRC_PCE |-> src_raw[1] == pin_change_event)
    else $error("pin change source not selected");

  AST_PORT_LATCH: assert property (
    src_r[1] == ecu_pkg::SRC_PIN && !pin_direction_bit[1] |-> src_raw[1] == port_out_latch[1])
    else $error("output pin does not follow the port latch");

  AST_TIMER_PICK: assert property (
    tsel_r[1] == 2'h2 |-> tmr_sel[1] == wide_timer_count_c)
    else $error("third timer not selected");

  COV_CAPTURE: cover property (capture_pulse[0] ##1 flag_r[0]);
  COV_PRESC16: cover property (ctl_r[0][3:0] == ecu_pkg::MODE_RISE16 && capture_pulse[0]);
  COV_BOTH:    cover property (capture_pulse[0] && capture_pulse[1]);
  COV_SHARED:  cover property (tsel_r[0] == tsel_r[1] && capture_pulse[0] && capture_pulse[1]);
  COV_LATCH:   cover property (!pin_direction_bit[1] && capture_pulse[1]);
endmodule
`default_nettype wire

/* File: test/ecu_event_model.sv */
// ecu_event_model: event sources and wide timer counts seen by the capture unit
// assumes the bench calls its tasks; counts change only when the bench sets them
`timescale 1ns/100ps
`default_nettype none
module ecu_event_model
(
  // clock
  input  wire logic        sys_clk,
  // wide timers
  output var  logic [15:0] cnt_a,
  output var  logic [15:0] cnt_b,
  output var  logic [15:0] cnt_c,
  // event sources
  output logic      [1:0]  pin,
  output logic      [1:0]  latch,
  output logic             cmp_one,
  output logic             cmp_two,
  output logic             pce
);
  // index: 0,1 pins, 2 cmp one, 3 cmp two, 4 pin change, 5,6 port latches
  logic [6:0] src_r = 7'h00;
  assign {latch, pce, cmp_two, cmp_one, pin} = src_r;
  initial
  begin
    cnt_a = 16'h0000;
    cnt_b = 16'h0000;
    cnt_c = 16'h0000;
  end
  ////////////////////////////////////////////////////////////////
  // synchronous, held counts
  // held counts stand in for a timer paused in sleep, so captures are predictable
  task automatic set_cnt(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
    @(posedge sys_clk);
    #3;
    cnt_a = a;
    cnt_b = b;
    cnt_c = c;
  endtask
  // sources change just after an edge, never on it
  task automatic flip(input int i);
    @(posedge sys_clk);
    #3;
    src_r[i] = ~src_r[i];
  endtask
endmodule
`default_nettype wire

/* File: test/ecu_top_bench.sv */
// ecu_top_bench: register-level tests of the two capture units
// assumes ecu_event_model drives the event sources and timer counts, except pin_direction_bit, which the bench drives
`timescale 1ns/100ps
`default_nettype none
module ecu_top_bench;
  logic        sys_clk   = 1'b0;
  logic        reset_n   = 1'b0;
  logic [7:0]  reg_addr  = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic        sleep_req = 1'b0;
  logic [1:0]  pin_dir   = 2'h3;
  logic [7:0]  reg_rdata;
  logic [15:0] cnt_a, cnt_b, cnt_c;
  logic [1:0]  pin, latch, flag, ien, cap, tsel0, tsel1;
  logic        cmp_one, cmp_two, pce, tick;
  int          bad_count = 0;
  int          checks    = 0;
  int          caps[2]   = '{0, 0};
  int          ticks     = 0;
  int          b;
  int          b0;

`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin bad_count++; \
  $display("[ERR] %0t got %h exp %h", $time, got, exp); end end

  always #12.5 sys_clk = ~sys_clk;

  ecu_top ecu_top_inst (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .wide_timer_count_a(cnt_a), .wide_timer_count_b(cnt_b), .wide_timer_count_c(cnt_c),
    .sleep_req(sleep_req), .instr_tick(tick), .capture_unit_pin(pin),
    .pin_direction_bit(pin_dir), .port_out_latch(latch), .comparator_one_out(cmp_one),
    .comparator_two_out(cmp_two), .pin_change_event(pce), .unit_event_flag(flag),
    .unit_event_enable(ien), .capture_pulse(cap), .timer_assign_field_0(tsel0),
    .timer_assign_field_1(tsel1));

  ecu_event_model ecu_event_model_inst (.sys_clk(sys_clk), .cnt_a(cnt_a), .cnt_b(cnt_b),
    .cnt_c(cnt_c), .pin(pin), .latch(latch), .cmp_one(cmp_one), .cmp_two(cmp_two), .pce(pce));

  always @(posedge sys_clk)
  begin
    if (cap[0] === 1'b1) caps[0]++;
    if (cap[1] === 1'b1) caps[1]++;
    if (tick === 1'b1) ticks++;
  end

  ////////////////////////////////////////////////////////////////
  task automatic test_done;
    if (bad_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask

  // n rising edges, each followed by a falling one, spaced past the sync latency
  task automatic ev(input int i, input int n);
    repeat (n)
    begin
      ecu_event_model_inst.flip(i);
      repeat (5) @(posedge sys_clk);
      ecu_event_model_inst.flip(i);
      repeat (5) @(posedge sys_clk);
    end
  endtask

  // configure a unit, let a mode change settle, then count captures of n edges
  task automatic ps(input int u, input logic [7:0] ctl, input int i, input int n, input int e);
    wr(8'(4 * u), ctl);
    repeat (4) @(posedge sys_clk);
    b = caps[u];
    ev(i, n);
    `CHK(caps[u] - b, e)
  endtask

  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    bad_count++;
    test_done();
  end

  initial
  begin
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    for (int a = 0; a < 12; a++) rd(8'(a), 8'h00);
    `CHK(tsel0, 2'h0)
    wr(8'h0b, 8'hff);
    rd(8'h0b, 8'h00);
    ecu_event_model_inst.set_cnt(16'h1234, 16'h5678, 16'h9abc);
    wr(8'h08, 8'h09);
    rd(8'h08, 8'h09);
    `CHK(tsel1, 2'h2)
    // every edge, falling, rising: two rising edges each
    ps(0, 8'h83, 0, 2, 4);
    ps(0, 8'h84, 0, 2, 2);
    ps(0, 8'h85, 0, 2, 2);
    rd(8'h02, 8'h78);
    rd(8'h03, 8'h56);
    repeat (30) @(posedge sys_clk);
    rd(8'h09, 8'h01);
    wr(8'h09, 8'h01);
    rd(8'h09, 8'h00);
    ecu_event_model_inst.set_cnt(16'h0000, 16'h1111, 16'h0000);
    ev(0, 1);
    ecu_event_model_inst.set_cnt(16'h0000, 16'hbeef, 16'h0000);
    ev(0, 1);
    rd(8'h02, 8'hef);
    rd(8'h03, 8'hbe);
    rd(8'h09, 8'h01);
    // unit off before a new prescaler, except the change to MODE_RISE16 after three edges, which carries the count on
    wr(8'h00, 8'h00);
    ps(0, 8'h86, 0, 8, 2);
    wr(8'h00, 8'h00);
    ps(0, 8'h87, 0, 16, 1);
    wr(8'h00, 8'h00);
    ps(0, 8'h86, 0, 3, 0);
    wr(8'h00, 8'h00);
    ps(0, 8'h86, 0, 3, 0);
    ps(0, 8'h86, 0, 1, 1);
    ps(0, 8'h86, 0, 3, 0);
    ps(0, 8'h87, 0, 13, 1);
    wr(8'h00, 8'h00);
    ps(0, 8'h86, 0, 3, 0);
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    `CHK(flag, 2'h0)
    ps(0, 8'h86, 0, 1, 0);
    // enabled but not capturing still clears the prescaler
    ps(0, 8'h86, 0, 2, 0);
    wr(8'h00, 8'h81);
    ps(0, 8'h86, 0, 1, 0);
    // unit 1 on the third timer while unit 0 keeps running
    wr(8'h08, 8'h08);
    ecu_event_model_inst.set_cnt(16'h0102, 16'h0304, 16'h9abc);
    for (int s = 0; s < 4; s++)
    begin
      wr(8'h05, 8'(s));
      ps(1, 8'h83, s + 1, 1, 2);
      ps(1, 8'h83, (s == 0) ? 2 : 1, 1, 0);
      rd(8'h06, 8'hbc);
    end
    wr(8'h05, 8'h00);
    pin_dir <= 2'h1;
    ps(1, 8'h83, 6, 1, 2);
    pin_dir <= 2'h3;
    ps(0, 8'h85, 0, 1, 1);
    rd(8'h02, 8'h02);
    // both units on the first timer and comparator one
    wr(8'h08, 8'h00);
    wr(8'h01, 8'h01);
    wr(8'h05, 8'h01);
    ecu_event_model_inst.set_cnt(16'h4321, 16'h0304, 16'h9abc);
    b0 = caps[0];
    ps(1, 8'h83, 2, 1, 2);
    `CHK(caps[0] - b0, 1)
    rd(8'h02, 8'h21);
    rd(8'h06, 8'h21);
    rd(8'h07, 8'h43);
    rd(8'h06, 8'h21);
    wr(8'h0a, 8'h02);
    rd(8'h0a, 8'h02);
    `CHK(ien, 2'h2)
    // sample off the edge so the tick counter has settled
    b = ticks;
    repeat (40) @(posedge sys_clk);
    #1;
    `CHK(ticks - b, 10)
    sleep_req <= 1'b1;
    b = ticks;
    repeat (40) @(posedge sys_clk);
    #1;
    `CHK(ticks - b, 0)
    test_done();
  end
endmodule
`default_nettype wire
